/* File: rtl/lswb_pkg.sv */
package lswb_pkg;

    // Byte offsets of the status words
    localparam logic [7:0] OFS_MAIN    = 8'h00;
    localparam logic [7:0] OFS_OPT     = 8'h04;
    localparam logic [7:0] OFS_EXT     = 8'h08;
    localparam logic [7:0] OFS_EV3_SEG = 8'h0c;
    localparam logic [7:0] OFS_EV3_END = 8'h10;

    // Word select codes
    localparam logic [2:0] SEL_MAIN    = 3'h0;
    localparam logic [2:0] SEL_OPT     = 3'h1;
    localparam logic [2:0] SEL_EXT     = 3'h2;
    localparam logic [2:0] SEL_EV3_SEG = 3'h3;
    localparam logic [2:0] SEL_EV3_END = 3'h4;
    localparam logic [2:0] SEL_NONE    = 3'h7;

    // Main status word bit positions
    localparam int MAIN_FMT    = 0;
    localparam int MAIN_SBRK   = 1;
    localparam int MAIN_AL2    = 8;
    localparam int MAIN_AL1    = 10;
    localparam int MAIN_ANY    = 12;
    localparam int MAIN_SP2    = 13;
    localparam int MAIN_REMOTE = 14;
    localparam int MAIN_MANUAL = 15;

    // Optional status word bit positions
    localparam int OPT_HOLD = 4;
    localparam int OPT_SKIP = 5;

    // Program status codes
    localparam logic [3:0] PST_RESET    = 4'h0;
    localparam logic [3:0] PST_UNUSED   = 4'h1;
    localparam logic [3:0] PST_HOLDBACK = 4'h6;

    // Reset values
    localparam logic        RST_FMT     = 1'h0;
    localparam logic [15:0] RST_EV3_SEG = 16'h0000;
    localparam logic        RST_EV3_END = 1'h0;

    // Internal loop, alarm and programmer signals
    typedef struct packed {
        logic       sensor_break; // Loop sensor break
        logic       alarm1;       // Alarm 1 active
        logic       alarm2;       // Alarm 2 active
        logic       sp2_sel;      // Second setpoint selected
        logic       remote_sp;    // Alternate setpoint enabled
        logic       manual_mode;  // Manual mode
        logic       self_tune;    // Self tune running
        logic       gain_set2;    // Second gain set active
        logic       relay_aa;     // Relay AA state
        logic       ramp_dwell;   // Ramp 0, dwell 1
        logic [3:0] prog_state;   // Programmer state code
        logic [3:0] segment;      // Current segment 1..8
        logic [3:0] program_num;  // Current program number
    } lswb_status_t;

endpackage

/* File: rtl/lswb_top.sv */
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module lswb_top #(
    parameter int ADDR_W = 8 // Byte address width
) (
    input  wire logic                  sys_clk,          // System clock
    input  wire logic                  srst,             // Sync reset
    input  wire logic [ADDR_W-1:0]     avs_address,      // Byte address
    input  wire logic                  avs_read,         // Read request
    input  wire logic                  avs_write,        // Write request
    input  wire logic [31:0]           avs_writedata,    // Write data
    input  wire logic [3:0]            avs_byteenable,   // Byte lanes
    output logic [31:0]                avs_readdata,     // Read data
    output logic                       avs_waitrequest,  // Stall
    input  wire lswb_pkg::lswb_status_t status,          // Loop signals
    input  wire logic                  hold_event,       // Hold seen pulse
    input  wire logic                  din1_pin,         // Digital input 1
    input  wire logic                  din2_pin,         // Digital input 2
    output logic                       data_fixed,       // Fixed format
    output logic                       skip_segment,     // Skip pulse
    output logic [15:0]                ev3_seg_mask,     // Segment events
    output logic                       ev3_end_mask      // End event
);

    // Sampled status and synchronised inputs
    lswb_pkg::lswb_status_t stat_q;      // Status snapshot
    logic [1:0]             din_meta;    // First sync stage
    logic [1:0]             din_sync;    // Second sync stage
    logic                   hold_logged; // Hold logged flag

    // Bus decode
    logic       wr_done; // Write taken this edge
    logic       rd_load; // Read data loaded this edge
    logic [2:0] sel;     // Selected word

    // Map a byte address onto a word select
    function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
        logic [7:0] w;
        w = 8'(a);
        if ((ADDR_W > 8) && ((a >> 8) != '0)) begin
            decode = lswb_pkg::SEL_NONE;
        end else begin
            unique case (w)
                lswb_pkg::OFS_MAIN:    decode = lswb_pkg::SEL_MAIN;
                lswb_pkg::OFS_OPT:     decode = lswb_pkg::SEL_OPT;
                lswb_pkg::OFS_EXT:     decode = lswb_pkg::SEL_EXT;
                lswb_pkg::OFS_EV3_SEG: decode = lswb_pkg::SEL_EV3_SEG;
                lswb_pkg::OFS_EV3_END: decode = lswb_pkg::SEL_EV3_END;
                default:               decode = lswb_pkg::SEL_NONE;
            endcase
        end
    endfunction

    // Force illegal programmer codes to reset
    function automatic logic [3:0] prog_code(input logic [3:0] s);
        if (s == lswb_pkg::PST_UNUSED || s > lswb_pkg::PST_HOLDBACK) begin
            prog_code = lswb_pkg::PST_RESET;
        end else begin
            prog_code = s;
        end
    endfunction

    assign sel     = decode(avs_address);
    assign wr_done = avs_write && !avs_waitrequest;
    assign rd_load = avs_read && avs_waitrequest;

    // One wait state, then answer
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            avs_waitrequest <= 1'h1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'h0;
        end else begin
            avs_waitrequest <= 1'h1;
        end
    end

    // Sample internal status every cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stat_q <= '0;
        end else begin
            stat_q <= status;
        end
    end

    // Two-stage sync of the digital input pins
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            din_meta <= 2'h0;
            din_sync <= 2'h0;
        end else begin
            din_meta <= {din1_pin, din2_pin};
            din_sync <= din_meta;
        end
    end

    // Format select, writable
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            data_fixed <= lswb_pkg::RST_FMT;
        end else if (wr_done && sel == lswb_pkg::SEL_MAIN && avs_byteenable[0]) begin
            data_fixed <= avs_writedata[lswb_pkg::MAIN_FMT];
        end
    end

    // Hold logged flag, set wins over clear
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hold_logged <= 1'h0;
        end else if (hold_event) begin
            hold_logged <= 1'h1;
        end else if (wr_done && sel == lswb_pkg::SEL_OPT && avs_byteenable[0]
                     && !avs_writedata[lswb_pkg::OPT_HOLD]) begin
            hold_logged <= 1'h0;
        end
    end

    // Skip command pulse
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            skip_segment <= 1'h0;
        end else begin
            skip_segment <= wr_done && sel == lswb_pkg::SEL_OPT && avs_byteenable[0]
                            && avs_writedata[lswb_pkg::OPT_SKIP];
        end
    end

    // Output-3 event masks
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ev3_seg_mask <= lswb_pkg::RST_EV3_SEG;
            ev3_end_mask <= lswb_pkg::RST_EV3_END;
        end else if (wr_done) begin
            if (sel == lswb_pkg::SEL_EV3_SEG) begin
                if (avs_byteenable[0]) begin
                    ev3_seg_mask[7:0] <= avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    ev3_seg_mask[15:8] <= avs_writedata[15:8];
                end
            end
            if (sel == lswb_pkg::SEL_EV3_END && avs_byteenable[0]) begin
                ev3_end_mask <= avs_writedata[0];
            end
        end
    end

    // Read data, latched as the wait state ends
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            avs_readdata <= 32'h00000000;
        end else if (rd_load) begin
            avs_readdata <= 32'h00000000;
            unique case (sel)
                lswb_pkg::SEL_MAIN: begin
                    avs_readdata[lswb_pkg::MAIN_SBRK] <= stat_q.sensor_break;
                    avs_readdata[lswb_pkg::MAIN_AL2]  <= stat_q.alarm2;
                    avs_readdata[lswb_pkg::MAIN_AL1]  <= stat_q.alarm1;
                    avs_readdata[lswb_pkg::MAIN_ANY]  <= stat_q.alarm1 | stat_q.alarm2;
                    avs_readdata[lswb_pkg::MAIN_SP2]    <= stat_q.sp2_sel;
                    avs_readdata[lswb_pkg::MAIN_REMOTE] <= stat_q.remote_sp;
                    avs_readdata[lswb_pkg::MAIN_MANUAL] <= stat_q.manual_mode;
                    avs_readdata[lswb_pkg::MAIN_FMT]    <= data_fixed;
                end
                lswb_pkg::SEL_OPT: begin
                    avs_readdata[3:0] <= prog_code(stat_q.prog_state);
                    avs_readdata[lswb_pkg::OPT_HOLD] <= hold_logged;
                    avs_readdata[6] <= stat_q.ramp_dwell;
                    avs_readdata[11:8] <= stat_q.segment;
                    avs_readdata[13] <= stat_q.relay_aa;
                    avs_readdata[14] <= din_sync[0];
                    avs_readdata[15] <= din_sync[1];
                end
                lswb_pkg::SEL_EXT: begin
                    avs_readdata[0] <= stat_q.self_tune;
                    avs_readdata[5] <= stat_q.gain_set2;
                    avs_readdata[6] <= stat_q.relay_aa;
                    avs_readdata[11:8] <= stat_q.program_num;
                end
                lswb_pkg::SEL_EV3_SEG: begin
                    avs_readdata[15:0] <= ev3_seg_mask;
                end
                lswb_pkg::SEL_EV3_END: begin
                    avs_readdata[0] <= ev3_end_mask;
                end
                default: begin
                    avs_readdata <= 32'h00000000;
                end
            endcase
        end
    end

    // Read of a given word has completed
    logic rd_main_q; // Main word loaded last edge
    logic rd_opt_q;  // Optional word loaded last edge
    logic rd_ext_q;  // Extended word loaded last edge

    // Checker helpers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_main_q <= 1'h0;
            rd_opt_q  <= 1'h0;
            rd_ext_q  <= 1'h0;
        end else begin
            rd_main_q <= rd_load && sel == lswb_pkg::SEL_MAIN;
            rd_opt_q  <= rd_load && sel == lswb_pkg::SEL_OPT;
            rd_ext_q  <= rd_load && sel == lswb_pkg::SEL_EXT;
        end
    end

    // Answer one cycle after request
    AST_WAIT_ONE: assert property (@(posedge sys_clk) disable iff (srst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest did not drop");

    AST_FMT_WRITE: assert property (@(posedge sys_clk) disable iff (srst)
        wr_done && sel == lswb_pkg::SEL_MAIN && avs_byteenable[0]
        |=> data_fixed == $past(avs_writedata[0]))
        else $error("format bit not stored");

    AST_MAIN_ALARMS: assert property (@(posedge sys_clk) disable iff (srst)
        rd_main_q |-> avs_readdata[1] == $past(stat_q.sensor_break)
            && avs_readdata[8] == $past(stat_q.alarm2)
            && avs_readdata[10] == $past(stat_q.alarm1))
        else $error("main word alarm bits wrong");

    AST_MAIN_ANY: assert property (@(posedge sys_clk) disable iff (srst)
        rd_main_q |-> avs_readdata[12] == (avs_readdata[8] | avs_readdata[10]))
        else $error("alarm summary wrong");

    AST_MAIN_MODE: assert property (@(posedge sys_clk) disable iff (srst)
        rd_main_q |-> avs_readdata[15:13] ==
            $past({stat_q.manual_mode, stat_q.remote_sp, stat_q.sp2_sel}))
        else $error("mode bits wrong");

    AST_MAIN_ZERO: assert property (@(posedge sys_clk) disable iff (srst)
        rd_main_q |-> avs_readdata[7:2] == 6'h00 && !avs_readdata[9]
            && !avs_readdata[11] && avs_readdata[31:16] == 16'h0000)
        else $error("main spare bits set");

    AST_PROG_CODE: assert property (@(posedge sys_clk) disable iff (srst)
        rd_opt_q |-> avs_readdata[3:0] != 4'h1 && avs_readdata[3:0] <= 4'h6)
        else $error("illegal program status");

    AST_HOLD_SET: assert property (@(posedge sys_clk) disable iff (srst)
        hold_event |=> hold_logged)
        else $error("hold event lost");

    AST_HOLD_NOSET: assert property (@(posedge sys_clk) disable iff (srst)
        !hold_event && !hold_logged |=> !hold_logged)
        else $error("hold flag set by host");

    AST_SKIP_CAUSE: assert property (@(posedge sys_clk) disable iff (srst)
        skip_segment |-> $past(wr_done && sel == lswb_pkg::SEL_OPT
            && avs_writedata[5]))
        else $error("skip without write");

    AST_OPT_ZERO: assert property (@(posedge sys_clk) disable iff (srst)
        rd_opt_q |-> !avs_readdata[7] && !avs_readdata[12] && !avs_readdata[5])
        else $error("optional zero bits set");

    AST_EXT_ZERO: assert property (@(posedge sys_clk) disable iff (srst)
        rd_ext_q |-> avs_readdata[15:12] == 4'h0 && !avs_readdata[1]
            && !avs_readdata[4] && avs_readdata[11:8] == $past(stat_q.program_num))
        else $error("extended word wrong");

    AST_EV3_SEG: assert property (@(posedge sys_clk) disable iff (srst)
        wr_done && sel == lswb_pkg::SEL_EV3_SEG && avs_byteenable[1:0] == 2'h3
        |=> ev3_seg_mask == $past(avs_writedata[15:0]))
        else $error("segment mask not stored");

    AST_EV3_END: assert property (@(posedge sys_clk) disable iff (srst)
        wr_done && sel == lswb_pkg::SEL_EV3_END && avs_byteenable[0]
        |=> ev3_end_mask == $past(avs_writedata[0]))
        else $error("end mask not stored");

    AST_OPT_FIELDS: assert property (@(posedge sys_clk) disable iff (srst)
        rd_opt_q |-> avs_readdata[11:8] == $past(stat_q.segment)
            && avs_readdata[13] == $past(stat_q.relay_aa)
            && avs_readdata[15:14] == $past(din_sync)
            && avs_readdata[6] == $past(stat_q.ramp_dwell))
        else $error("optional word fields wrong");

    AST_EXT_FIELDS: assert property (@(posedge sys_clk) disable iff (srst)
        rd_ext_q |-> avs_readdata[0] == $past(stat_q.self_tune)
            && avs_readdata[5] == $past(stat_q.gain_set2)
            && avs_readdata[6] == $past(stat_q.relay_aa))
        else $error("extended word fields wrong");

    // Main scenarios
    COV_MAIN_READ: cover property (@(posedge sys_clk) disable iff (srst)
        rd_main_q && avs_readdata[12]);

    COV_SKIP: cover property (@(posedge sys_clk) disable iff (srst)
        skip_segment);

    COV_HOLD_RACE: cover property (@(posedge sys_clk) disable iff (srst)
        hold_event && wr_done && sel == lswb_pkg::SEL_OPT);

    COV_EV3_WRITE: cover property (@(posedge sys_clk) disable iff (srst)
        wr_done && sel == lswb_pkg::SEL_EV3_SEG);

endmodule

`default_nettype wire

/* File: test/lswb_host.sv */
`timescale 1ns/1ps
`default_nettype none

// Host-side bus master for the register bus
module lswb_host (
    input  wire logic        sys_clk,          // System clock
    input  wire logic [31:0] avs_readdata,     // Read data
    input  wire logic        avs_waitrequest,  // Stall
    output logic      [7:0]  avs_address,      // Byte address
    output logic             avs_read,         // Read request
    output logic             avs_write,        // Write request
    output logic      [31:0] avs_writedata,    // Write data
    output logic      [3:0]  avs_byteenable    // Byte lanes
);
    // Idle bus at time zero
    initial begin
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h00000000;
        avs_byteenable = 4'h0;
    end

    // One transfer, held until waitrequest is sampled low
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
                        input logic [3:0] be, output logic [15:0] q);
        @(posedge sys_clk);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= {16'h0000, d};
        avs_byteenable <= be;
        // Waits on the slave; the bench timeout ends a hang
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[15:0];
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        // Released lines do not keep the last value
        avs_writedata <= ~avs_writedata;
        avs_address   <= ~avs_address;
    endtask
endmodule

`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic                  sys_clk;          // System clock
    logic                  srst;             // Sync reset
    logic [7:0]            avs_address;      // Byte address
    logic                  avs_read;         // Read request
    logic                  avs_write;        // Write request
    logic [31:0]           avs_writedata;    // Write data
    logic [3:0]            avs_byteenable;   // Byte lanes
    logic [31:0]           avs_readdata;     // Read data
    logic                  avs_waitrequest;  // Stall
    lswb_pkg::lswb_status_t status;          // Loop signals
    logic                  hold_event;       // Hold seen pulse
    logic                  din1_pin;         // Digital input 1
    logic                  din2_pin;         // Digital input 2
    logic                  data_fixed;       // Fixed format
    logic                  skip_segment;     // Skip pulse
    logic [15:0]           ev3_seg_mask;     // Segment events
    logic                  ev3_end_mask;     // End event
    int                    fails;            // Mismatch count
    int                    check_count;      // Compare count
    int                    cycles;           // Timeout counter

    lswb_top dut (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .status(status),
        .hold_event(hold_event), .din1_pin(din1_pin), .din2_pin(din2_pin), .data_fixed(data_fixed),
        .skip_segment(skip_segment), .ev3_seg_mask(ev3_seg_mask), .ev3_end_mask(ev3_end_mask));

    lswb_host host (.sys_clk(sys_clk), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));

    // Clock, 5 ns period
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails = fails + 1;
            stop_test();
        end
    end

    // Compare and report
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count = check_count + 1;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            fails = fails + 1;
        end
    endtask

    task automatic rd(input logic [7:0] a, input string n, input logic [15:0] e);
        logic [15:0] r;
        host.xfer(1'b0, a, 16'h0000, 4'h3, r);
        chk(n, e, r);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] be);
        logic [15:0] r;
        host.xfer(1'b1, a, d, be, r);
    endtask

    // Let the snapshot and input synchronisers settle
    task automatic settle();
        repeat (4) @(posedge sys_clk);
    endtask

    initial begin
        srst = 1'b1; status = '0; hold_event = 1'b0; din1_pin = 1'b0; din2_pin = 1'b0;
        fails = 0; check_count = 0; cycles = 0;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        // Reset state of all five words
        rd(lswb_pkg::OFS_MAIN, "main rst", 16'h0000);
        rd(lswb_pkg::OFS_OPT, "opt rst", 16'h0000);
        rd(lswb_pkg::OFS_EXT, "ext rst", 16'h0000);
        rd(lswb_pkg::OFS_EV3_SEG, "seg rst", 16'h0000);
        rd(lswb_pkg::OFS_EV3_END, "end rst", 16'h0000);
        $display("test reset done");
        // Main word: break, alarms, setpoint, remote, manual
        status.sensor_break <= 1'b1; status.alarm1 <= 1'b1; settle();
        rd(lswb_pkg::OFS_MAIN, "main a1", 16'h1402);
        status.sensor_break <= 1'b0; status.alarm1 <= 1'b0; status.alarm2 <= 1'b1; settle();
        rd(lswb_pkg::OFS_MAIN, "main a2", 16'h1100);
        status.alarm2 <= 1'b0; status.sp2_sel <= 1'b1; status.remote_sp <= 1'b1; status.manual_mode <= 1'b1; settle();
        rd(lswb_pkg::OFS_MAIN, "main mode", 16'he000);
        status <= '0; settle();
        // Format bit writable, key bits and spares ignored
        wr(lswb_pkg::OFS_MAIN, 16'hffff, 4'h3);
        #1 chk("data_fixed", 16'h0001, {15'h0000, data_fixed});
        rd(lswb_pkg::OFS_MAIN, "main wr", 16'h0001);
        wr(lswb_pkg::OFS_MAIN, 16'h0000, 4'h3);
        #1 chk("data_free", 16'h0000, {15'h0000, data_fixed});
        $display("test main done");
        // Every program status code, unused codes read as reset
        for (int i = 0; i < 16; i++) begin
            status.prog_state <= 4'(i); settle();
            rd(lswb_pkg::OFS_OPT, "prog", (i == 1 || i > 6) ? 16'h0000 : 16'(i));
        end
        status.prog_state <= 4'h0; status.segment <= 4'h8; status.ramp_dwell <= 1'b1;
        status.relay_aa <= 1'b1; din1_pin <= 1'b1; settle();
        rd(lswb_pkg::OFS_OPT, "opt seg8", 16'ha840);
        rd(lswb_pkg::OFS_EXT, "ext relay", 16'h0040);
        status.segment <= 4'h1; status.ramp_dwell <= 1'b0; status.relay_aa <= 1'b0;
        din1_pin <= 1'b0; din2_pin <= 1'b1; settle();
        rd(lswb_pkg::OFS_OPT, "opt seg1", 16'h4100);
        // Skip pulse, read-only and zero bits ignore writes
        wr(lswb_pkg::OFS_OPT, 16'hffff, 4'h3);
        #1 chk("skip hi", 16'h0001, {15'h0000, skip_segment});
        @(posedge sys_clk);
        #1 chk("skip lo", 16'h0000, {15'h0000, skip_segment});
        rd(lswb_pkg::OFS_OPT, "opt wr", 16'h4100);
        // Hold flag: device sets, host clears only
        @(posedge sys_clk);
        hold_event <= 1'b1;
        @(posedge sys_clk);
        hold_event <= 1'b0; settle();
        rd(lswb_pkg::OFS_OPT, "hold set", 16'h4110);
        wr(lswb_pkg::OFS_OPT, 16'h0010, 4'h3);
        rd(lswb_pkg::OFS_OPT, "hold kept", 16'h4110);
        wr(lswb_pkg::OFS_OPT, 16'h0000, 4'h1);
        rd(lswb_pkg::OFS_OPT, "hold clr", 16'h4100);
        wr(lswb_pkg::OFS_OPT, 16'h0010, 4'h3);
        rd(lswb_pkg::OFS_OPT, "hold noset", 16'h4100);
        // Hold event on the clearing write's own edge: set wins
        fork
            wr(lswb_pkg::OFS_OPT, 16'h0000, 4'h1);
            begin
                repeat (2) @(posedge sys_clk);
                hold_event <= 1'b1;
                @(posedge sys_clk);
                hold_event <= 1'b0;
            end
        join
        rd(lswb_pkg::OFS_OPT, "hold race", 16'h4110);
        $display("test optional done");
        // Extended word fields, nothing writable
        status.self_tune <= 1'b1; status.gain_set2 <= 1'b1; status.program_num <= 4'hf; settle();
        rd(lswb_pkg::OFS_EXT, "ext", 16'h0f21);
        wr(lswb_pkg::OFS_EXT, 16'hffff, 4'h3);
        rd(lswb_pkg::OFS_EXT, "ext wr", 16'h0f21);
        $display("test extended done");
        // Event masks, lane enables, spares and an unmapped place
        wr(lswb_pkg::OFS_EV3_SEG, 16'ha5c3, 4'h3);
        rd(lswb_pkg::OFS_EV3_SEG, "seg", 16'ha5c3);
        chk("seg pins", 16'ha5c3, ev3_seg_mask);
        wr(lswb_pkg::OFS_EV3_SEG, 16'hffff, 4'h1);
        rd(lswb_pkg::OFS_EV3_SEG, "seg lane", 16'ha5ff);
        wr(lswb_pkg::OFS_EV3_END, 16'hffff, 4'h3);
        rd(lswb_pkg::OFS_EV3_END, "end", 16'h0001);
        chk("end pin", 16'h0001, {15'h0000, ev3_end_mask});
        wr(8'h14, 16'h0000, 4'h3);
        rd(8'h14, "unmapped", 16'h0000);
        rd(lswb_pkg::OFS_EV3_SEG, "seg kept", 16'ha5ff);
        $display("test events done");
        stop_test();
    end
endmodule

`default_nettype wire
